/* File: rsx_pkg.sv */
// Purpose: shared constants and carriers for the core register set
// Assumes: one clock, synchronous active-high reset
// Notes: memory-mapped offsets are 8-bit data-space addresses
package rsx_pkg;
	localparam logic [7:0] ADDR_FLAGS = 8'hBC;
	localparam logic [7:0] ADDR_STACK = 8'hBD;
	localparam logic [7:0] ADDR_IDX_HIGH = 8'hBE;
	localparam logic [7:0] ADDR_IDX_LOW = 8'hBF;
	localparam logic [7:0] STACK_BASE = 8'h30;
	localparam logic [3:0] STACK_STEP = 4'h2;
	localparam logic [3:0] SP_RESET = 4'hF;
	localparam logic [11:0] PC_RESET = 12'h800;
	localparam logic [11:0] X_RESET = 12'h000;
	localparam logic [7:0] ACC_RESET = 8'h00;
	localparam logic [7:0] FLAGS_RESET = 8'h00;
	localparam int FLAG_C = 0;
	localparam int FLAG_H = 1;
	localparam int FLAG_Z = 2;
	localparam int FLAG_N = 3;
	localparam int FLAG_G = 4;
	localparam int FLAG_R = 5;
	localparam int X_SPACE = 11;
	typedef enum logic [4:0] {
		OP_NONE = 5'h00,
		OP_LOAD_A = 5'h01,
		OP_ADD = 5'h02,
		OP_ADC = 5'h03,
		OP_SUB = 5'h04,
		OP_AND = 5'h05,
		OP_OR = 5'h06,
		OP_XOR = 5'h07,
		OP_INC_A = 5'h08,
		OP_DEC_A = 5'h09,
		OP_RLC = 5'h0A,
		OP_RRC = 5'h0B,
		OP_SET_C = 5'h0C,
		OP_CLR_C = 5'h0D,
		OP_CARRY_LOAD = 5'h0E,
		OP_CARRY_FLIP = 5'h0F,
		OP_SET_G = 5'h10,
		OP_CLR_G = 5'h11,
		OP_LOAD_X = 5'h12,
		OP_INC_X = 5'h13,
		OP_DEC_X = 5'h14,
		OP_JUMP = 5'h15,
		OP_PC_STEP = 5'h16,
		OP_CALL = 5'h17,
		OP_IRQ_ENTRY = 5'h18,
		OP_SUB_EXIT = 5'h19,
		OP_IRQ_EXIT = 5'h1A
	} rsx_op_t;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_PUSH_LO = 3'b001,
		ST_PUSH_HI = 3'b011,
		ST_PULL_HI = 3'b100,
		ST_PULL_LO = 3'b101
	} rsx_state_t;
	typedef struct packed {
		rsx_op_t op;
		logic [7:0] arg;
		logic [11:0] word;
	} rsx_cmd_t;
	typedef struct packed {
		logic valid;
		logic write;
		logic [7:0] offset;
	} rsx_idx_req_t;
	typedef struct packed {
		logic re;
		logic we;
		logic [7:0] addr;
		logic [7:0] wdata;
	} rsx_mm_req_t;
endpackage

/* File: rsx_core_regs.sv */
// Purpose: architectural register set of a small 8-bit core
// Assumes: stack memory answers a read combinationally from stack_addr_r
// Notes: commands are ignored while busy_r is high
`timescale 1ns/1ps
module rsx_core_regs (
	input wire logic core_clk,
	input wire logic rst,
	input rsx_pkg::rsx_cmd_t cmd,
	input rsx_pkg::rsx_idx_req_t idx_req,
	input rsx_pkg::rsx_mm_req_t mm_req,
	input wire logic irq_pending,
	input wire logic eeprom_write_busy,
	input wire logic [7:0] stack_rdata,
	output logic [7:0] acc_r,
	output logic [11:0] pc_addr_r,
	output logic [7:0] flags_r,
	output logic [11:0] idx_addr_r,
	output logic idx_re_r,
	output logic idx_we_r,
	output logic [7:0] stack_addr_r,
	output logic [7:0] stack_wdata_r,
	output logic stack_we_r,
	output logic stack_re_r,
	output logic [7:0] mm_rdata_r,
	output logic irq_recognise_r,
	output logic busy_r
);
	rsx_pkg::rsx_state_t state_r, state_nxt;
	logic [11:0] x_r, x_nxt;
	logic [10:0] pc_r, pc_nxt;
	logic [3:0] sp_r, sp_nxt;
	logic [7:0] acc_nxt, flags_nxt;
	logic [10:0] target_r;
	logic irq_exit_r, irq_entry_r;
	logic [9:0] alu_out;
	logic [7:0] mm_rdata_nxt;
	logic [11:0] idx_addr_nxt;
	logic [7:0] stack_addr_nxt, stack_wdata_nxt;

	function automatic logic [9:0] alu_eval(input rsx_pkg::rsx_op_t op, input logic [7:0] a, input logic [7:0] b,
		input logic cin, input logic hin);
		logic [8:0] s;
		logic [4:0] n;
		logic h;
		logic c;
		s = {1'b0, a};
		n = {1'b0, a[3:0]};
		h = hin;
		c = cin;
		unique case (op)
			rsx_pkg::OP_ADD, rsx_pkg::OP_ADC: begin
				s = {1'b0, a} + {1'b0, b} + {8'h00, cin & (op == rsx_pkg::OP_ADC)};
				n = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin & (op == rsx_pkg::OP_ADC)};
				c = s[8];
				h = n[4];
			end
			rsx_pkg::OP_SUB: begin
				s = {1'b0, a} - {1'b0, b};
				n = {1'b0, a[3:0]} - {1'b0, b[3:0]};
				c = s[8];
				h = n[4];
			end
			rsx_pkg::OP_LOAD_A: s = {1'b0, b};
			rsx_pkg::OP_AND: s = {1'b0, a & b};
			rsx_pkg::OP_OR: s = {1'b0, a | b};
			rsx_pkg::OP_XOR: s = {1'b0, a ^ b};
			rsx_pkg::OP_INC_A: s = {1'b0, a} + 9'h001;
			rsx_pkg::OP_DEC_A: s = {1'b0, a} - 9'h001;
			rsx_pkg::OP_RLC: begin
				s = {1'b0, a[6:0], cin};
				c = a[7];
			end
			rsx_pkg::OP_RRC: begin
				s = {1'b0, cin, a[7:1]};
				c = a[0];
			end
			default: s = {1'b0, a};
		endcase
		return {h, c, s[7:0]};
	endfunction

	// decoding
	wire idle = (state_r == rsx_pkg::ST_IDLE);
	wire take_cmd = idle && (cmd.op != rsx_pkg::OP_NONE);
	wire is_alu = take_cmd && (cmd.op >= rsx_pkg::OP_LOAD_A) && (cmd.op <= rsx_pkg::OP_RRC);
	wire flag_cmd = take_cmd && (cmd.op >= rsx_pkg::OP_SET_C) && (cmd.op <= rsx_pkg::OP_CLR_G);
	wire start_push = take_cmd && ((cmd.op == rsx_pkg::OP_CALL) || (cmd.op == rsx_pkg::OP_IRQ_ENTRY));
	wire start_pull = take_cmd && ((cmd.op == rsx_pkg::OP_SUB_EXIT) || (cmd.op == rsx_pkg::OP_IRQ_EXIT));
	wire mm_wr_flags = mm_req.we && (mm_req.addr == rsx_pkg::ADDR_FLAGS);
	wire mm_wr_stack = mm_req.we && (mm_req.addr == rsx_pkg::ADDR_STACK);
	wire mm_wr_idx_high = mm_req.we && (mm_req.addr == rsx_pkg::ADDR_IDX_HIGH);
	wire mm_wr_idx_low = mm_req.we && (mm_req.addr == rsx_pkg::ADDR_IDX_LOW);
	wire [3:0] sp_down1 = sp_r - 4'h1;
	wire [3:0] sp_up1 = sp_r + 4'h1;
	wire [3:0] sp_up2 = sp_r + rsx_pkg::STACK_STEP;
	wire [10:0] ea_low = x_r[10:0] + {3'b000, idx_req.offset};
	wire x_space = x_r[rsx_pkg::X_SPACE];

	assign alu_out = alu_eval(cmd.op, acc_r, cmd.arg, flags_r[rsx_pkg::FLAG_C], flags_r[rsx_pkg::FLAG_H]);

	// stack sequencer
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			rsx_pkg::ST_IDLE: begin
				if (start_push) begin
					state_nxt = rsx_pkg::ST_PUSH_LO;
				end else if (start_pull) begin
					state_nxt = rsx_pkg::ST_PULL_HI;
				end
			end
			rsx_pkg::ST_PUSH_LO: state_nxt = rsx_pkg::ST_PUSH_HI;
			rsx_pkg::ST_PUSH_HI: state_nxt = rsx_pkg::ST_IDLE;
			rsx_pkg::ST_PULL_HI: state_nxt = rsx_pkg::ST_PULL_LO;
			rsx_pkg::ST_PULL_LO: state_nxt = rsx_pkg::ST_IDLE;
			default: state_nxt = rsx_pkg::ST_IDLE;
		endcase
	end

	// stack port: low byte at the free slot, high byte just below it
	always_comb begin
		stack_addr_nxt = stack_addr_r;
		stack_wdata_nxt = 8'h00;
		if (start_push) begin
			stack_addr_nxt = rsx_pkg::STACK_BASE | {4'h0, sp_r};
			stack_wdata_nxt = pc_r[7:0];
		end else if (state_r == rsx_pkg::ST_PUSH_LO) begin
			stack_addr_nxt = rsx_pkg::STACK_BASE | {4'h0, sp_down1};
			stack_wdata_nxt = {5'b00000, pc_r[10:8]};
		end else if (start_pull) begin
			stack_addr_nxt = rsx_pkg::STACK_BASE | {4'h0, sp_up1};
		end else if (state_r == rsx_pkg::ST_PULL_HI) begin
			stack_addr_nxt = rsx_pkg::STACK_BASE | {4'h0, sp_up2};
		end
	end

	// program counter and stack index
	always_comb begin
		pc_nxt = pc_r;
		sp_nxt = sp_r;
		if (state_r == rsx_pkg::ST_PUSH_HI) begin
			sp_nxt = sp_r - rsx_pkg::STACK_STEP;
			// continue at the vector once stacked
			pc_nxt = target_r;
		end else if (state_r == rsx_pkg::ST_PULL_HI) begin
			pc_nxt = {stack_rdata[2:0], pc_r[7:0]};
		end else if (state_r == rsx_pkg::ST_PULL_LO) begin
			pc_nxt = {pc_r[10:8], stack_rdata};
			sp_nxt = sp_r + rsx_pkg::STACK_STEP;
		end else if (take_cmd && (cmd.op == rsx_pkg::OP_JUMP)) begin
			pc_nxt = cmd.word[10:0];
		end else if (take_cmd && (cmd.op == rsx_pkg::OP_PC_STEP)) begin
			pc_nxt = pc_r + 11'h001;
		end
		if (mm_wr_stack && idle) begin
			sp_nxt = mm_req.wdata[3:0];
		end
	end

	// index pointer
	always_comb begin
		x_nxt = x_r;
		if (take_cmd && (cmd.op == rsx_pkg::OP_LOAD_X)) begin
			x_nxt = cmd.word;
		end else if (take_cmd && (cmd.op == rsx_pkg::OP_INC_X)) begin
			// space bit kept out of counting
			x_nxt = {x_space, x_r[10:0] + 11'h001};
		end else if (take_cmd && (cmd.op == rsx_pkg::OP_DEC_X)) begin
			x_nxt = {x_space, x_r[10:0] - 11'h001};
		end else if (mm_wr_idx_high) begin
			x_nxt = {mm_req.wdata[3:0], x_r[7:0]};
		end else if (mm_wr_idx_low) begin
			x_nxt = {x_r[11:8], mm_req.wdata};
		end
	end

	// accumulator and flags
	always_comb begin
		acc_nxt = acc_r;
		flags_nxt = flags_r;
		if (is_alu) begin
			acc_nxt = alu_out[7:0];
			flags_nxt[rsx_pkg::FLAG_C] = alu_out[8];
			flags_nxt[rsx_pkg::FLAG_H] = alu_out[9];
			flags_nxt[rsx_pkg::FLAG_Z] = (alu_out[7:0] == 8'h00);
			flags_nxt[rsx_pkg::FLAG_N] = alu_out[7];
		end else if (flag_cmd) begin
			unique case (cmd.op)
				rsx_pkg::OP_SET_C: flags_nxt[rsx_pkg::FLAG_C] = 1'b1;
				rsx_pkg::OP_CLR_C: flags_nxt[rsx_pkg::FLAG_C] = 1'b0;
				rsx_pkg::OP_CARRY_LOAD: flags_nxt[rsx_pkg::FLAG_C] = cmd.arg[0];
				rsx_pkg::OP_CARRY_FLIP: flags_nxt[rsx_pkg::FLAG_C] = ~flags_r[rsx_pkg::FLAG_C];
				rsx_pkg::OP_SET_G: flags_nxt[rsx_pkg::FLAG_G] = 1'b1;
				rsx_pkg::OP_CLR_G: flags_nxt[rsx_pkg::FLAG_G] = 1'b0;
				default: flags_nxt = flags_r;
			endcase
		end else if (state_r == rsx_pkg::ST_PUSH_HI && irq_entry_r) begin
			flags_nxt[rsx_pkg::FLAG_G] = 1'b0;
		end else if (state_r == rsx_pkg::ST_PULL_LO && irq_exit_r) begin
			flags_nxt[rsx_pkg::FLAG_G] = 1'b1;
		end else if (mm_wr_flags) begin
			flags_nxt = mm_req.wdata;
		end
		// write flag mirrors the eeprom, never stored
		flags_nxt[rsx_pkg::FLAG_R] = eeprom_write_busy;
		flags_nxt[7:6] = 2'b00;
	end

	// memory-mapped reads; accumulator and counter have no location
	always_comb begin
		mm_rdata_nxt = 8'h00;
		if (mm_req.re) begin
			unique case (mm_req.addr)
				rsx_pkg::ADDR_FLAGS: mm_rdata_nxt = flags_r;
				rsx_pkg::ADDR_STACK: mm_rdata_nxt = {4'h0, sp_r};
				rsx_pkg::ADDR_IDX_HIGH: mm_rdata_nxt = {5'b00000, x_r[10:8]};
				rsx_pkg::ADDR_IDX_LOW: mm_rdata_nxt = x_r[7:0];
				default: mm_rdata_nxt = 8'h00;
			endcase
		end
	end

	// space bit picks data or program window
	assign idx_addr_nxt = x_space ? {1'b1, ea_low} : {4'h0, ea_low[7:0]};

	always_ff @(posedge core_clk) begin
		if (rst) begin
			state_r <= rsx_pkg::ST_IDLE;
			pc_r <= rsx_pkg::PC_RESET[10:0];
			pc_addr_r <= rsx_pkg::PC_RESET;
			sp_r <= rsx_pkg::SP_RESET;
			x_r <= rsx_pkg::X_RESET;
			acc_r <= rsx_pkg::ACC_RESET;
			flags_r <= rsx_pkg::FLAGS_RESET;
		end else begin
			state_r <= state_nxt;
			pc_r <= pc_nxt;
			pc_addr_r <= {1'b1, pc_nxt};
			sp_r <= sp_nxt;
			x_r <= x_nxt;
			acc_r <= acc_nxt;
			flags_r <= flags_nxt;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			target_r <= 11'h000;
			irq_entry_r <= 1'b0;
			irq_exit_r <= 1'b0;
		end else if (take_cmd) begin
			target_r <= cmd.word[10:0];
			irq_entry_r <= (cmd.op == rsx_pkg::OP_IRQ_ENTRY);
			irq_exit_r <= (cmd.op == rsx_pkg::OP_IRQ_EXIT);
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			stack_addr_r <= rsx_pkg::STACK_BASE;
			stack_wdata_r <= 8'h00;
			stack_we_r <= 1'b0;
			stack_re_r <= 1'b0;
			idx_addr_r <= 12'h000;
			idx_re_r <= 1'b0;
			idx_we_r <= 1'b0;
			mm_rdata_r <= 8'h00;
			irq_recognise_r <= 1'b0;
			busy_r <= 1'b0;
		end else begin
			stack_addr_r <= stack_addr_nxt;
			stack_wdata_r <= stack_wdata_nxt;
			stack_we_r <= (state_nxt == rsx_pkg::ST_PUSH_LO) || (state_nxt == rsx_pkg::ST_PUSH_HI);
			stack_re_r <= (state_nxt == rsx_pkg::ST_PULL_HI) || (state_nxt == rsx_pkg::ST_PULL_LO);
			idx_addr_r <= idx_addr_nxt;
			idx_re_r <= idx_req.valid && !idx_req.write;
			// code space is read only through the index
			idx_we_r <= idx_req.valid && idx_req.write && !x_space;
			mm_rdata_r <= mm_rdata_nxt;
			irq_recognise_r <= irq_pending && flags_nxt[rsx_pkg::FLAG_G] && (state_nxt == rsx_pkg::ST_IDLE);
			busy_r <= (state_nxt != rsx_pkg::ST_IDLE);
		end
	end

	a_pc_after_reset: assert property (@(posedge core_clk) $past(rst) && !rst |-> pc_addr_r == 12'h800)
		else $error("counter not 0x800 after reset");
	a_sp_after_reset: assert property (@(posedge core_clk) $past(rst) && !rst |-> sp_r == 4'hF && !flags_r[4])
		else $error("stack index or mask wrong after reset");
	a_push_low_first: assert property (@(posedge core_clk) disable iff (rst)
		start_push |=> stack_we_r && stack_wdata_r == $past(pc_r[7:0]) && stack_addr_r == {4'h3, $past(sp_r)}
		##1 stack_we_r && stack_wdata_r == {5'b00000, $past(pc_r[10:8], 2)}
		&& stack_addr_r == {4'h3, $past(sp_r, 2) - 4'h1})
		else $error("push order or data wrong");
	a_push_step_two: assert property (@(posedge core_clk) disable iff (rst)
		start_push |-> ##3 sp_r == $past(sp_r, 3) - 4'h2)
		else $error("push did not subtract two");
	a_pull_step_two: assert property (@(posedge core_clk) disable iff (rst)
		start_pull |-> ##3 (sp_r == $past(sp_r, 3) + 4'h2) && !busy_r)
		else $error("pull did not add two");
	a_irq_exit_mask: assert property (@(posedge core_clk) disable iff (rst)
		take_cmd && cmd.op == rsx_pkg::OP_IRQ_EXIT |-> ##3 flags_r[4])
		else $error("interrupt exit left mask clear");
	a_irq_entry_mask: assert property (@(posedge core_clk) disable iff (rst)
		take_cmd && cmd.op == rsx_pkg::OP_IRQ_ENTRY |-> ##3 !flags_r[4] && pc_r == $past(cmd.word[10:0], 3))
		else $error("entry did not clear mask or load vector");
	a_code_no_write: assert property (@(posedge core_clk) disable iff (rst) idx_we_r |-> !idx_addr_r[11])
		else $error("write into code space");
	a_ea_sum: assert property (@(posedge core_clk) disable iff (rst)
		idx_req.valid && x_r[11] |=> idx_addr_r == {1'b1, $past(x_r[10:0]) + {3'b000, $past(idx_req.offset)}})
		else $error("effective address wrong");
	a_data_window: assert property (@(posedge core_clk) disable iff (rst)
		idx_req.valid && !x_r[11] |=> idx_addr_r[11:8] == 4'h0)
		else $error("data-space address left its window");
	a_index_space_kept: assert property (@(posedge core_clk) disable iff (rst)
		take_cmd && (cmd.op == rsx_pkg::OP_INC_X || cmd.op == rsx_pkg::OP_DEC_X) |=> x_r[11] == $past(x_r[11]))
		else $error("index counting touched the space bit");
	a_zero_flag: assert property (@(posedge core_clk) disable iff (rst) $past(is_alu) |-> flags_r[2] == (acc_r == 8'h00))
		else $error("zero flag disagrees with result");
	a_neg_flag: assert property (@(posedge core_clk) disable iff (rst)
		$past(is_alu) |-> flags_r[rsx_pkg::FLAG_N] == acc_r[7])
		else $error("negative flag disagrees with result");
	a_high_read_zero: assert property (@(posedge core_clk) disable iff (rst)
		mm_req.re && mm_req.addr == rsx_pkg::ADDR_IDX_HIGH |=> mm_rdata_r[7:3] == 5'b00000)
		else $error("high index read shows space bit");
	a_stack_mapped: assert property (@(posedge core_clk) disable iff (rst)
		mm_wr_stack && idle |=> sp_r == $past(mm_req.wdata[3:0]))
		else $error("mapped write to stack index lost");
	a_pc_step: assert property (@(posedge core_clk) disable iff (rst)
		take_cmd && cmd.op == rsx_pkg::OP_PC_STEP |=> pc_r == $past(pc_r) + 11'h001)
		else $error("counter did not step by one");
	a_mask_gates_irq: assert property (@(posedge core_clk) disable iff (rst) irq_recognise_r |-> flags_r[4] && !busy_r)
		else $error("interrupt recognised while masked");
endmodule

/* File: rsx_core_regs_tb.sv */
// Purpose: self-checking bench for the core register set
// Assumes: inputs change on the falling edge of core_clk
// Notes: the bench plays the stack memory through stack_rdata
`timescale 1ns/1ps
module testbench;
	logic core_clk = 1'h0;
	logic rst = 1'h1;
	rsx_pkg::rsx_cmd_t cmd = '0;
	rsx_pkg::rsx_idx_req_t idx_req = '0;
	rsx_pkg::rsx_mm_req_t mm_req = '0;
	logic irq_pending = 1'h0;
	logic eeprom_write_busy = 1'h0;
	logic [7:0] stack_rdata = 8'hC3;
	logic [7:0] acc_r, flags_r, stack_addr_r, stack_wdata_r, mm_rdata_r, rd;
	logic [11:0] pc_addr_r, idx_addr_r;
	logic idx_re_r, idx_we_r, stack_we_r, stack_re_r, irq_recognise_r, busy_r;
	int errors = 0;
	int total_checks = 0;
	int cycles = 0;

	rsx_core_regs DUT (.core_clk(core_clk), .rst(rst), .cmd(cmd), .idx_req(idx_req), .mm_req(mm_req),
		.irq_pending(irq_pending), .eeprom_write_busy(eeprom_write_busy), .stack_rdata(stack_rdata),
		.acc_r(acc_r), .pc_addr_r(pc_addr_r), .flags_r(flags_r), .idx_addr_r(idx_addr_r),
		.idx_re_r(idx_re_r), .idx_we_r(idx_we_r), .stack_addr_r(stack_addr_r),
		.stack_wdata_r(stack_wdata_r), .stack_we_r(stack_we_r), .stack_re_r(stack_re_r),
		.mm_rdata_r(mm_rdata_r), .irq_recognise_r(irq_recognise_r), .busy_r(busy_r));

	always #2.5 core_clk = ~core_clk;

	task test_done;
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// whole run needs fewer than two hundred cycles
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 3000) begin
			errors++;
			test_done;
		end
	end

	task chk(input logic [11:0] got, input logic [11:0] exp);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// leaves the bench in the cycle after the command was taken
	task do_cmd(input rsx_pkg::rsx_op_t op, input logic [7:0] arg, input logic [11:0] word);
		@(negedge core_clk);
		cmd.op = op;
		cmd.arg = arg;
		cmd.word = word;
		@(posedge core_clk);
		@(negedge core_clk);
		cmd = '0;
	endtask

	task mm(input logic we, input logic [7:0] addr, input logic [7:0] wd);
		@(negedge core_clk);
		mm_req = '{~we, we, addr, wd};
		@(posedge core_clk);
		@(negedge core_clk);
		mm_req = '0;
		rd = mm_rdata_r;
	endtask

	task idx(input logic wr, input logic [7:0] off);
		@(negedge core_clk);
		idx_req = '{1'h1, wr, off};
		@(posedge core_clk);
		@(negedge core_clk);
		idx_req = '0;
	endtask

	task alu(input rsx_pkg::rsx_op_t op, input logic [7:0] arg, input logic [7:0] eacc,
		input logic [3:0] eflg, input logic [3:0] msk);
		do_cmd(op, arg, 12'h000);
		chk(acc_r, eacc);
		chk(flags_r[3:0] & msk, eflg);
	endtask

	// stack read data is only valid while the matching address is presented
	task pull(input rsx_pkg::rsx_op_t op);
		do_cmd(op, 8'h00, 12'h000);
		chk(stack_re_r, 1'h1);
		chk(stack_addr_r, 8'h3E);
		stack_rdata = 8'h01;
		@(negedge core_clk);
		chk(stack_addr_r, 8'h3F);
		stack_rdata = 8'hA5;
		@(negedge core_clk);
		stack_rdata = 8'h3C;
		chk(stack_re_r, 1'h0);
	endtask

	task reset_check;
		@(negedge core_clk);
		rst = 1'h1;
		repeat (3) @(posedge core_clk);
		@(negedge core_clk);
		rst = 1'h0;
		chk(acc_r, 8'h00);
		chk(pc_addr_r, 12'h800);
		chk(flags_r[4], 1'h0);
		mm(1'h0, rsx_pkg::ADDR_STACK, 8'h00);
		chk(rd, 8'h0F);
		$display("test reset done");
	endtask

	task test_alu;
		alu(rsx_pkg::OP_LOAD_A, 8'h80, 8'h80, 4'h8, 4'hF);
		alu(rsx_pkg::OP_ADD, 8'h80, 8'h00, 4'h5, 4'hF);
		alu(rsx_pkg::OP_LOAD_A, 8'h0F, 8'h0F, 4'h1, 4'hF);
		alu(rsx_pkg::OP_ADD, 8'h01, 8'h10, 4'h2, 4'hF);
		alu(rsx_pkg::OP_SUB, 8'h11, 8'hFF, 4'hB, 4'hF);
		alu(rsx_pkg::OP_XOR, 8'hFF, 8'h00, 4'h7, 4'hF);
		alu(rsx_pkg::OP_OR, 8'h81, 8'h81, 4'hB, 4'hF);
		alu(rsx_pkg::OP_AND, 8'h01, 8'h01, 4'h3, 4'hF);
		alu(rsx_pkg::OP_DEC_A, 8'h00, 8'h00, 4'h7, 4'hF);
		alu(rsx_pkg::OP_INC_A, 8'h00, 8'h01, 4'h3, 4'hF);
		alu(rsx_pkg::OP_ADC, 8'hFE, 8'h00, 4'h7, 4'hF);
		alu(rsx_pkg::OP_CLR_C, 8'h00, 8'h00, 4'h6, 4'hF);
		alu(rsx_pkg::OP_SET_C, 8'h00, 8'h00, 4'h7, 4'hF);
		alu(rsx_pkg::OP_CARRY_FLIP, 8'h00, 8'h00, 4'h6, 4'hF);
		alu(rsx_pkg::OP_CARRY_LOAD, 8'h01, 8'h00, 4'h7, 4'hF);
		alu(rsx_pkg::OP_LOAD_A, 8'h80, 8'h80, 4'hB, 4'hF);
		alu(rsx_pkg::OP_RLC, 8'h00, 8'h01, 4'h1, 4'h1);
		alu(rsx_pkg::OP_RRC, 8'h00, 8'h80, 4'h1, 4'h1);
		$display("test alu done");
	endtask

	task test_index;
		do_cmd(rsx_pkg::OP_LOAD_X, 8'h00, 12'h0F0);
		idx(1'h1, 8'h20);
		chk(idx_addr_r, 12'h010);
		chk(idx_we_r, 1'h1);
		do_cmd(rsx_pkg::OP_LOAD_X, 8'h00, 12'hE05);
		idx(1'h0, 8'h05);
		chk(idx_addr_r, 12'hE0A);
		chk(idx_re_r, 1'h1);
		idx(1'h1, 8'h05);
		chk(idx_we_r, 1'h0);
		mm(1'h0, rsx_pkg::ADDR_IDX_HIGH, 8'h00);
		chk(rd, 8'h06);
		mm(1'h0, rsx_pkg::ADDR_IDX_LOW, 8'h00);
		chk(rd, 8'h05);
		do_cmd(rsx_pkg::OP_LOAD_X, 8'h00, 12'hFFF);
		do_cmd(rsx_pkg::OP_INC_X, 8'h00, 12'h000);
		idx(1'h0, 8'h00);
		chk(idx_addr_r, 12'h800);
		do_cmd(rsx_pkg::OP_DEC_X, 8'h00, 12'h000);
		mm(1'h0, rsx_pkg::ADDR_IDX_HIGH, 8'h00);
		chk(rd, 8'h07);
		mm(1'h1, rsx_pkg::ADDR_IDX_HIGH, 8'h03);
		mm(1'h1, rsx_pkg::ADDR_IDX_LOW, 8'h44);
		idx(1'h1, 8'h01);
		chk(idx_addr_r, 12'h045);
		chk(idx_we_r, 1'h1);
		$display("test index done");
	endtask

	task test_stack;
		do_cmd(rsx_pkg::OP_JUMP, 8'h00, 12'h9A5);
		chk(pc_addr_r, 12'h9A5);
		do_cmd(rsx_pkg::OP_PC_STEP, 8'h00, 12'h000);
		chk(pc_addr_r, 12'h9A6);
		do_cmd(rsx_pkg::OP_SET_G, 8'h00, 12'h000);
		do_cmd(rsx_pkg::OP_CALL, 8'h00, 12'h8F0);
		chk(stack_we_r, 1'h1);
		chk(stack_addr_r, 8'h3F);
		chk(stack_wdata_r, 8'hA6);
		@(negedge core_clk);
		chk(stack_addr_r, 8'h3E);
		chk(stack_wdata_r, 8'h01);
		@(negedge core_clk);
		chk(busy_r, 1'h0);
		chk(pc_addr_r, 12'h8F0);
		mm(1'h0, rsx_pkg::ADDR_STACK, 8'h00);
		chk(rd, 8'h0D);
		pull(rsx_pkg::OP_SUB_EXIT);
		chk(pc_addr_r, 12'h9A5);
		mm(1'h0, rsx_pkg::ADDR_STACK, 8'h00);
		chk(rd, 8'h0F);
		$display("test stack done");
	endtask

	task test_irq;
		irq_pending = 1'h1;
		@(negedge core_clk);
		chk(irq_recognise_r, 1'h1);
		do_cmd(rsx_pkg::OP_CLR_G, 8'h00, 12'h000);
		@(negedge core_clk);
		chk(irq_recognise_r, 1'h0);
		do_cmd(rsx_pkg::OP_SET_G, 8'h00, 12'h000);
		do_cmd(rsx_pkg::OP_IRQ_ENTRY, 8'h00, 12'h8E0);
		chk(flags_r[4], 1'h1);
		chk(stack_wdata_r, 8'hA5);
		@(negedge core_clk);
		@(negedge core_clk);
		chk(pc_addr_r, 12'h8E0);
		chk(flags_r[4], 1'h0);
		do_cmd(rsx_pkg::OP_SET_G, 8'h00, 12'h000);
		chk(flags_r[4], 1'h1);
		do_cmd(rsx_pkg::OP_CLR_G, 8'h00, 12'h000);
		pull(rsx_pkg::OP_IRQ_EXIT);
		chk(pc_addr_r, 12'h9A5);
		chk(flags_r[4], 1'h1);
		irq_pending = 1'h0;
		$display("test irq done");
	endtask

	task test_flags;
		eeprom_write_busy = 1'h1;
		@(negedge core_clk);
		chk(flags_r[5], 1'h1);
		mm(1'h1, rsx_pkg::ADDR_FLAGS, 8'hFF);
		chk(flags_r, 8'h3F);
		mm(1'h0, rsx_pkg::ADDR_FLAGS, 8'h00);
		chk(rd, 8'h3F);
		eeprom_write_busy = 1'h0;
		mm(1'h1, rsx_pkg::ADDR_FLAGS, 8'h00);
		chk(flags_r, 8'h00);
		mm(1'h0, 8'h40, 8'h00);
		chk(rd, 8'h00);
		mm(1'h1, rsx_pkg::ADDR_STACK, 8'h07);
		mm(1'h0, rsx_pkg::ADDR_STACK, 8'h00);
		chk(rd, 8'h07);
		$display("test flags done");
	endtask

	initial begin
		reset_check();
		test_alu();
		test_index();
		test_stack();
		test_irq();
		test_flags();
		// a second reset in mid-run must drop the mask again
		do_cmd(rsx_pkg::OP_SET_G, 8'h00, 12'h000);
		reset_check();
		test_done();
	end
endmodule
